// *** design/hpsc_map.svh ***
// register offsets, field positions and reset values of the hot-plug slot register bank
`ifndef HPSC_MAP_SVH
`define HPSC_MAP_SVH
`define HPSC_SLOT_OFS        8'hD8
`define HPSC_DEVCAP2_OFS     8'hE4
`define HPSC_ABP_EN_BIT      0
`define HPSC_PFD_EN_BIT      1
`define HPSC_PDC_EN_BIT      3
`define HPSC_CC_EN_BIT       4
`define HPSC_HPI_EN_BIT      5
`define HPSC_AIC_LSB         6
`define HPSC_PIC_LSB         8
`define HPSC_PCC_BIT         10
`define HPSC_DLLSC_EN_BIT    12
`define HPSC_CTRL_WMASK      16'h17FB
`define HPSC_CTRL_RESET      16'h03C0
`define HPSC_ABP_BIT         16
`define HPSC_PFD_BIT         17
`define HPSC_MRLC_BIT        18
`define HPSC_PDC_BIT         19
`define HPSC_CC_BIT          20
`define HPSC_MRLS_BIT        21
`define HPSC_PDS_BIT         22
`define HPSC_DLLSC_BIT       24
`define HPSC_DEVCAP2_VALUE   32'h00040800
`endif

// *** design/hpsc_pkg.sv ***
// types shared by the hot-plug slot register bank
package hpsc_pkg;
	typedef enum logic [1:0] {HPSC_IND_RSVD, HPSC_IND_ON, HPSC_IND_BLINK, HPSC_IND_OFF} hpsc_ind_t;
	typedef enum logic [1:0] {HPSC_RESP_OKAY = 2'h0, HPSC_RESP_SLVERR = 2'h2} hpsc_resp_t;
endpackage

// *** design/hpsc_slot_regs.sv ***
// hot-plug slot control and status registers with axi4-lite access
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "hpsc_map.svh"
// Contract
// R1 - button event gated by control bit 0
// R2 - power fault event gated by bit 1
// R3 - presence change event gated by bit 3
// R4 - command completion gated by bit 4, interrupt only
// R5 - bit 5 master enable for hot-plug interrupt
// R6 - attention indicator field 7:6, resets off
// R7 - attention field write sends indicator message
// R8 - power indicator field 9:8, resets off
// R9 - power field write sends indicator message
// R10 - bit 10 drives slot power off request
// R11 - bit 12 enables link-active change notification
// R12 - button pressed flag, write one clears
// R13 - power fault flag, write one clears
// R14 - latch sensor changed flag, read only
// R15 - presence changed flag, write one clears
// R16 - command completed flag, write one clears
// R17 - bit 21 shows live latch sensor
// R18 - bit 22 presence, one without slot
// R19 - presence reset value inverts the strap
// R20 - link-active change flag, write one clears
// R21 - second capabilities bit 11 reads one
// R22 - capabilities bits 19:18 read 01b, others zero
// R23 - interrupt while enabled flags pending
// R24 - reserved bits read zero, ignore writes
module hpsc_slot_regs
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        slot_implemented,
	input  wire logic        card_presence_strap,
	input  wire logic        attn_button_pin,
	input  wire logic        power_fault_pin,
	input  wire logic        latch_open_pin,
	input  wire logic        cmd_done_pin,
	input  wire logic        link_active,
	output logic             hotplug_irq,
	output logic             hotplug_wake,
	output logic             dll_notify,
	output logic [1:0]       attn_indicator,
	output logic [1:0]       power_indicator,
	output logic             slot_power_off,
	output logic             attn_msg_send,
	output logic             power_msg_send
);
	// --------------------------------------------------------------
	// pin synchronisers and edge detection
	// --------------------------------------------------------------
	// slot pins are asynchronous; only the second stage is looked at
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] prev_reg;
	logic       prim_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
		end
		else
		begin
			sync1_reg <= {card_presence_strap, cmd_done_pin, latch_open_pin, power_fault_pin, attn_button_pin};
			sync2_reg <= sync1_reg;
		end
	end
	wire btn_s    = sync2_reg[0];
	wire pfault_s = sync2_reg[1];
	wire latch_s  = sync2_reg[2];
	wire cmd_s    = sync2_reg[3];
	wire card_presence_strap_s  = ~sync2_reg[4];
	wire pres_s   = card_presence_strap_s | ~slot_implemented;
	// link_active comes from the port's own logic on aclk, so it is not synchronised
	logic link_prev_reg;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			prev_reg      <= 5'h00;
			prim_reg      <= 1'b1;
			link_prev_reg <= 1'b0;
		end
		else
		begin
			prev_reg      <= {card_presence_strap_s, sync2_reg[3:0]};
			prim_reg      <= 1'b0;
			link_prev_reg <= link_active;
		end
	end
	// the first cycle after release only primes history, so a strap reading present is not seen as a change; one reading empty still is
	wire ev_btn    = btn_s & ~prev_reg[0] & ~prim_reg;
	wire ev_pfault = pfault_s & ~prev_reg[1] & ~prim_reg;
	wire ev_latch  = (latch_s ^ prev_reg[2]) & ~prim_reg;
	wire ev_cmd    = cmd_s & ~prev_reg[3] & ~prim_reg;
	wire ev_pres   = (card_presence_strap_s ^ prev_reg[4]) & ~prim_reg & slot_implemented;
	wire ev_link   = (link_active ^ link_prev_reg) & ~prim_reg;

	// --------------------------------------------------------------
	// axi4-lite handshake
	// --------------------------------------------------------------
	logic        aw_held_reg;
	logic        w_held_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire  = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_held_reg | aw_fire;
	wire w_have  = w_held_reg | w_fire;
	wire wr_go   = aw_have & w_have & ~s_axi_bvalid;
	wire [7:0]  wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
	wire [3:0]  wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
	wire wr_slot = wr_go & (wr_addr[7:2] == `HPSC_SLOT_OFS >> 2);
	wire wr_cap  = wr_go & (wr_addr[7:2] == `HPSC_DEVCAP2_OFS >> 2);
	// control lives in the low half, status in the high half of the same word
	wire [15:0] ctrl_wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & `HPSC_CTRL_WMASK;
	wire [15:0] sts_w1c    = {{8{wr_strb[3]}}, {8{wr_strb[2]}}} & wr_data[31:16] & {16{wr_slot}};
	wire attn_wr = wr_slot & wr_strb[0];
	wire pwr_wr  = wr_slot & wr_strb[1];
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg  <= 1'b0;
			w_held_reg   <= 1'b0;
			awaddr_reg   <= 8'h00;
			wdata_reg    <= 32'h00000000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end
		else
		begin
			if (aw_fire)
				awaddr_reg <= s_axi_awaddr;
			if (w_fire)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			aw_held_reg <= aw_have & ~wr_go;
			w_held_reg  <= w_have & ~wr_go;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_slot | wr_cap) ? hpsc_pkg::HPSC_RESP_OKAY : hpsc_pkg::HPSC_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// slot control and status
	// --------------------------------------------------------------
	logic [15:0] ctrl_reg;
	logic        abp_reg;
	logic        pfd_reg;
	logic        mrlc_reg;
	logic        pdc_reg;
	logic        cc_reg;
	logic        dllsc_reg;
	logic        pres_reg;
	wire [15:0] ctrl_next = (ctrl_reg & ~ctrl_wmask) | (wr_data[15:0] & ctrl_wmask); // R24
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg       <= `HPSC_CTRL_RESET; // R6 R8 R10
			abp_reg        <= 1'b0;
			pfd_reg        <= 1'b0;
			mrlc_reg       <= 1'b0;
			pdc_reg        <= 1'b0;
			cc_reg         <= 1'b0;
			dllsc_reg      <= 1'b0;
			attn_msg_send  <= 1'b0;
			power_msg_send <= 1'b0;
		end
		else
		begin
			if (wr_slot)
				ctrl_reg <= ctrl_next;
			attn_msg_send  <= attn_wr; // R7
			power_msg_send <= pwr_wr; // R9
			// a new event beats a write-one-clear in the same cycle
			abp_reg   <= ev_btn | (abp_reg & ~sts_w1c[`HPSC_ABP_BIT-16]); // R12
			pfd_reg   <= ev_pfault | (pfd_reg & ~sts_w1c[`HPSC_PFD_BIT-16]); // R13
			mrlc_reg  <= ev_latch | mrlc_reg; // R14
			pdc_reg   <= ev_pres | (pdc_reg & ~sts_w1c[`HPSC_PDC_BIT-16]); // R15
			cc_reg    <= ev_cmd | (cc_reg & ~sts_w1c[`HPSC_CC_BIT-16]); // R16
			dllsc_reg <= ev_link | (dllsc_reg & ~sts_w1c[`HPSC_DLLSC_BIT-16]); // R20
		end
	end
	// presence state: reset value is the inverse of the strap, taken once the synchroniser settles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pres_reg <= 1'b0;
		else
			pres_reg <= pres_s; // R18 R19
	end

	// --------------------------------------------------------------
	// outputs and interrupt
	// --------------------------------------------------------------
	assign attn_indicator  = ctrl_reg[`HPSC_AIC_LSB+1:`HPSC_AIC_LSB]; // R6
	assign power_indicator = ctrl_reg[`HPSC_PIC_LSB+1:`HPSC_PIC_LSB]; // R8
	assign slot_power_off  = ctrl_reg[`HPSC_PCC_BIT]; // R10
	wire gate_abp   = abp_reg & ctrl_reg[`HPSC_ABP_EN_BIT]; // R1
	wire gate_pfd   = pfd_reg & ctrl_reg[`HPSC_PFD_EN_BIT]; // R2
	wire gate_pdc   = pdc_reg & ctrl_reg[`HPSC_PDC_EN_BIT]; // R3
	wire gate_cc    = cc_reg & ctrl_reg[`HPSC_CC_EN_BIT]; // R4
	wire gate_dllsc = dllsc_reg & ctrl_reg[`HPSC_DLLSC_EN_BIT]; // R11
	wire hp_en      = ctrl_reg[`HPSC_HPI_EN_BIT]; // R5
	// command completion never wakes the system
	assign hotplug_irq  = hp_en & (gate_abp | gate_pfd | gate_pdc | gate_cc | gate_dllsc); // R23
	// the master enable gates only the interrupt, so a wake still follows its own enables
	assign hotplug_wake = gate_abp | gate_pfd | gate_pdc | gate_dllsc; // R4
	assign dll_notify   = gate_dllsc; // R11

	// --------------------------------------------------------------
	// read path
	// --------------------------------------------------------------
	wire [15:0] sts_word = {7'h00, dllsc_reg, 1'b0, pres_reg, latch_s, cc_reg, pdc_reg, mrlc_reg, pfd_reg, abp_reg}; // R14 R17 R24
	wire rd_slot = s_axi_araddr[7:2] == `HPSC_SLOT_OFS >> 2;
	wire rd_cap  = s_axi_araddr[7:2] == `HPSC_DEVCAP2_OFS >> 2;
	wire [31:0] rd_word = rd_slot ? {sts_word, ctrl_reg & `HPSC_CTRL_WMASK} :
		(rd_cap ? `HPSC_DEVCAP2_VALUE : 32'h00000000); // R21 R22
	assign s_axi_arready = ~s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= (rd_slot | rd_cap) ? hpsc_pkg::HPSC_RESP_OKAY : hpsc_pkg::HPSC_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

// *** sim/hpsc_slot_regs_sva.sv ***
// port assertions for the slot register bank
`timescale 1ns/1ps
module hpsc_slot_regs_sva
(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [1:0] attn_indicator,
	input wire logic [1:0] power_indicator,
	input wire logic       slot_power_off,
	input wire logic       attn_msg_send,
	input wire logic       power_msg_send
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire wt = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	wire wd = wt & (s_axi_awaddr == 8'hD8);
	a_attn_msg: assert property (attn_msg_send == $past(wd & s_axi_wstrb[0]))
		else $error("attention pulse");
	a_pwr_msg: assert property (power_msg_send == $past(wd & s_axi_wstrb[1]))
		else $error("power pulse");
	a_attn_hold: assert property (!$stable(attn_indicator) |-> $past(wd))
		else $error("attention moved");
	a_pind_hold: assert property (!$stable(power_indicator) |-> $past(wd))
		else $error("power ind moved");
	a_poff_hold: assert property ($changed(slot_power_off) |-> $past(wd))
		else $error("power off moved");
	a_write_resp: assert property (wt |=> s_axi_bvalid)
		else $error("no write response");
	a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("no read response");
	a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("stray read data");
endmodule

// *** sim/hpsc_slot_model.sv ***
// slot side: button, fault, latch, presence and command done pins
`timescale 1ns/1ps
module hpsc_slot_model
(
	input wire logic aclk,
	input wire logic go,
	output logic     attn_button_pin,
	output logic     power_fault_pin,
	output logic     latch_open_pin,
	output logic     cmd_done_pin,
	output logic     card_presence_strap
);
	logic [2:0] cnt_reg = 3'h0;
	logic       gone_reg = 1'b0;
	// pulses last several cycles so the synchronisers cannot miss them
	assign attn_button_pin = cnt_reg != 3'h0;
	assign power_fault_pin = cnt_reg != 3'h0;
	assign cmd_done_pin = cnt_reg[2];
	// card pulled: latch opens and the strap reads empty
	assign latch_open_pin = gone_reg;
	assign card_presence_strap = gone_reg;
	always @(posedge aclk)
	begin
		cnt_reg <= go ? 3'h7 : cnt_reg - 3'(cnt_reg != 3'h0);
		gone_reg <= gone_reg | go;
	end
endmodule

// *** sim/hotplug_slot_control_status_bench.sv ***
// self-checking bench for the slot register bank
`timescale 1ns/1ps
module hotplug_slot_control_status_bench;
	logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0, link_active = 1'b0, slot_implemented = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'hE3A84595;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, attn_indicator, power_indicator;
	logic        hotplug_irq, hotplug_wake, dll_notify, slot_power_off, attn_msg_send, power_msg_send;
	logic        attn_button_pin, power_fault_pin, latch_open_pin, cmd_done_pin, card_presence_strap;
	logic [33:0] exp_q[$];
	logic [1:0]  bresp_q[$];
	logic [15:0] m;
	int          err_count = 0, cmp_count = 0;
	hpsc_slot_regs uut (.*);
	hpsc_slot_model slot (.*);
	initial forever #2.5 aclk = ~aclk;
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// aw and w offered together; ready waits are unbounded, the watchdog cuts a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		bresp_q.push_back((a == 8'hD8 || a == 8'hE4) ? 2'h0 : 2'h2);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		exp_q.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	always @(posedge aclk)
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
	always @(posedge aclk)
		if (s_axi_bvalid && s_axi_bready)
			chk(34'(s_axi_bresp), 34'(bresp_q.pop_front()));
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#20000;
		err_count++;
		report_and_stop();
	end
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(8'hD8, {2'h0, 32'h004003C0});
		rd(8'hE4, {2'h0, 32'h00040800});
		rd(8'h10, {2'h2, 32'h00000000});
		wr(8'hE4, 32'hFFFFFFFF, 4'hF);
		wr(8'h10, 32'hFFFFFFFF, 4'hF);
		rd(8'hE4, {2'h0, 32'h00040800});
		rd(8'hD8, {2'h0, 32'h004003C0});
		for (int i = 1; i < 4; i++)
		begin
			wr(8'hD8, 32'(i * 16'h0140), 4'h3);
			chk({attn_indicator, power_indicator}, 34'(i * 5));
		end
		wr(8'hD8, 32'h0000FFFF, 4'h3);
		rd(8'hD8, {2'h0, 32'h004017FB});
		chk(34'(slot_power_off), 34'h1);
		link_active <= 1'b1;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (12) @(posedge aclk);
		rd(8'hD8, {2'h0, 32'h013F17FB});
		chk({hotplug_irq, dll_notify}, 34'h3);
		for (int k = 0; k < 8; k++)
		begin
			m = 16'(xs()) & 16'h003B;
			wr(8'hD8, {16'h0000, m | 16'h03C0}, 4'h3);
			chk(34'(hotplug_irq), 34'(m[5] & |{m[0], m[1], m[3], m[4]}));
			chk(34'(hotplug_wake), 34'(|{m[0], m[1], m[3]}));
		end
		wr(8'hD8, 32'hFFFF0000, 4'hC);
		rd(8'hD8, {2'h0, 16'h0024, m | 16'h03C0});
		chk(34'(hotplug_irq), 34'h0);
		slot_implemented <= 1'b0;
		repeat (3) @(posedge aclk);
		rd(8'hD8, {2'h0, 16'h0064, m | 16'h03C0});
		report_and_stop();
	end
endmodule
bind hpsc_slot_regs hpsc_slot_regs_sva chk (.*);
